// ### hw/endpoint_buffer_memory_map.sv
// Address decoder and endpoint buffer allocation for the USB controller
//
// Behaviour
// RULE_01: 16 kB of program/data RAM sits at address zero with no control registers in it.
// RULE_02: Download, upload, setup pointer and boot load reach only main RAM and scratch RAM.
// RULE_03: Control registers decode in the 512-byte window E500 to E6FF.
// RULE_04: Waveform descriptors occupy the 128 bytes E400 to E47F.
// RULE_05: The eight 512-byte buffers of endpoints 2, 4, 6, 8 fill F000 to FFFF.
// RULE_06: The eight setup bytes live at E6B8 to E6BF, apart from the endpoint zero buffer.
// RULE_07: There are three 64-byte buffers for endpoints 0 and 1 and eight 512-byte buffers.
// RULE_08: Endpoint zero is one bidirectional 64-byte buffer and the only control endpoint.
// RULE_09: Endpoint 1 has separate 64-byte in and out buffers, bulk or interrupt only.
// RULE_10: Big buffers allow bulk, interrupt, iso; ep4/ep8 up to double, ep2/ep6 up to quad.
// RULE_11: Big buffer allocation is one of twelve fixed layouts; endpoints 0 and 1 never change.
// RULE_12: At full speed only the first 64 bytes of each buffer are used, 512 at high speed.
// RULE_13: Buffer space unused at full speed is never handed to another function.
// RULE_14: Full-speed alternate settings follow the default table with 64-byte endpoints.
// RULE_15: High-speed settings follow the same pattern with 512-byte endpoints 2 to 8.
// RULE_16: The host never moves packets over 64 bytes on endpoint 1.
// RULE_17: Reserved ranges have no side effects and read as a harmless fixed value.
`timescale 1ns/1ps
`include "epmap_defines.svh"

module endpoint_buffer_memory_map (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_loader,
  input wire logic i_high_speed,
  input wire logic [3:0] i_layout,
  input wire logic [1:0] i_alt,
  output logic [3:0] o_region,
  output logic o_hit,
  output logic o_wr_ok,
  output logic o_loader_ok,
  output logic [2:0] o_big_block,
  output logic [8:0] o_offset,
  output logic o_fs_unused,
  output logic [7:0] o_undef_data,
  output logic [3:0] o_layout,
  output logic [2:0] o_depth_ep2,
  output logic [2:0] o_depth_ep4,
  output logic [2:0] o_depth_ep6,
  output logic [2:0] o_depth_ep8,
  output logic [9:0] o_pkt_ep0,
  output logic [9:0] o_pkt_ep1,
  output logic [9:0] o_pkt_big,
  output logic [1:0] o_type_ep1,
  output logic [1:0] o_type_ep2,
  output logic [1:0] o_type_ep4,
  output logic [1:0] o_type_ep6,
  output logic [1:0] o_type_ep8
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Depths of ep2, ep4, ep6, ep8 packed 3 bits each, one fixed layout
  // Depth 0 marks an endpoint absent from that layout
  // Depth 2 is double, 3 triple, 4 quad buffering
  // Only ep2 and ep6 ever go beyond double buffering
  // Ep4 and ep8 stay at double or absent in every row
  // Each row spends at most eight 512-byte blocks in total
  // Row 11 doubles as the default so a stray index stays legal
  function automatic logic [11:0] layout_depths(input logic [3:0] idx);
    unique case (idx)
      4'h0: layout_depths = {3'h2, 3'h2, 3'h2, 3'h2};
      4'h1: layout_depths = {3'h2, 3'h0, 3'h2, 3'h2};
      4'h2: layout_depths = {3'h2, 3'h2, 3'h2, 3'h0};
      4'h3: layout_depths = {3'h2, 3'h0, 3'h2, 3'h0};
      4'h4: layout_depths = {3'h3, 3'h0, 3'h2, 3'h2};
      4'h5: layout_depths = {3'h3, 3'h0, 3'h3, 3'h0};
      4'h6: layout_depths = {3'h2, 3'h0, 3'h3, 3'h2};
      4'h7: layout_depths = {3'h2, 3'h0, 3'h4, 3'h0};
      4'h8: layout_depths = {3'h4, 3'h0, 3'h2, 3'h0};
      4'h9: layout_depths = {3'h4, 3'h0, 3'h4, 3'h0};
      4'ha: layout_depths = {3'h3, 3'h0, 3'h2, 3'h0};
      default: layout_depths = {3'h2, 3'h0, 3'h3, 3'h0};
    endcase
  endfunction

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Priority order matters: the setup window sits inside the
  // register window and must win over it
  // Main RAM holds no control registers, only program and data
  // Reserved holes decode to their own code so nothing acts on them
  // Unmapped space gives region none, no hit and no write
  // All decode results are registered, one cycle behind the address
  // Loader accesses outside the two RAMs are refused, not redirected
  // Full-speed dead space in the big buffers refuses writes as well
  logic [3:0] next_region;
  logic next_hit;
  logic next_wr_ok;
  logic next_loader_ok;
  logic [2:0] next_big_block;
  logic [8:0] next_offset;
  logic next_fs_unused;

  always_comb begin
    epmap_pkg::region_t r;
    r = epmap_pkg::reg_none;
    if (i_addr <= `MAIN_RAM_TOP) begin
      r = epmap_pkg::reg_main_ram;                                   // [RULE_01]
    end else if (in_range(i_addr, `SCRATCH_BASE, `SCRATCH_TOP)) begin
      r = epmap_pkg::reg_scratch;
    end else if (in_range(i_addr, `WAVE_BASE, `WAVE_TOP)) begin
      r = epmap_pkg::reg_wave;                                       // [RULE_04]
    end else if (in_range(i_addr, `SETUP_BASE, `SETUP_TOP)) begin
      r = epmap_pkg::reg_setup;                                      // [RULE_06]
    end else if (in_range(i_addr, `CREG_BASE, `CREG_TOP)) begin
      r = epmap_pkg::reg_creg;                                       // [RULE_03]
    end else if (in_range(i_addr, `EP0_BASE, `EP0_TOP)) begin
      r = epmap_pkg::reg_ep0;                                        // [RULE_07] [RULE_08]
    end else if (in_range(i_addr, `ENDPOINT_ONE_OUT_BUFFER_BASE, `ENDPOINT_ONE_OUT_BUFFER_TOP)) begin
      r = epmap_pkg::reg_ep1_out;                                    // [RULE_09]
    end else if (in_range(i_addr, `ENDPOINT_ONE_IN_BUFFER_BASE, `ENDPOINT_ONE_IN_BUFFER_TOP)) begin
      r = epmap_pkg::reg_ep1_in;                                     // [RULE_09]
    end else if (i_addr >= `BIG_BASE) begin
      r = epmap_pkg::reg_big;                                        // [RULE_05] [RULE_07]
    end else if (in_range(i_addr, `RSV0_BASE, `RSV0_TOP)
              || in_range(i_addr, `RSV1_BASE, `RSV1_TOP)
              || in_range(i_addr, `RSV2_BASE, `RSV2_TOP)
              || in_range(i_addr, `RSV3_BASE, `RSV3_TOP)) begin
      r = epmap_pkg::reg_reserved;                                   // [RULE_17]
    end
    next_region = r;
    next_hit = (r != epmap_pkg::reg_none) && (r != epmap_pkg::reg_reserved);
    // Loader paths reach only the two RAMs
    next_loader_ok = i_loader && ((r == epmap_pkg::reg_main_ram)
                     || (r == epmap_pkg::reg_scratch));              // [RULE_02]
    next_big_block = (r == epmap_pkg::reg_big) ? i_addr[11:9] : 3'h0;
    next_offset = (r == epmap_pkg::reg_big) ? i_addr[8:0] : {3'h0, i_addr[5:0]};
    // Beyond the first 64 bytes at full speed: dead space, no other use
    next_fs_unused = (r == epmap_pkg::reg_big) && !i_high_speed
                     && (i_addr[8:0] >= 9'(`FS_PKT_MAX));            // [RULE_12] [RULE_13]
    next_wr_ok = i_wr && next_hit && !next_fs_unused
                 && (!i_loader || next_loader_ok);                    // [RULE_17]
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_region <= 4'h0;
      o_hit <= 1'b0;
      o_wr_ok <= 1'b0;
      o_loader_ok <= 1'b0;
      o_big_block <= 3'h0;
      o_offset <= 9'h000;
      o_fs_unused <= 1'b0;
      o_undef_data <= `UNDEF_READ;
    end else begin
      o_region <= next_region;
      o_hit <= next_hit;
      o_wr_ok <= next_wr_ok;
      o_loader_ok <= next_loader_ok;
      o_big_block <= next_big_block;
      o_offset <= next_offset;
      o_fs_unused <= next_fs_unused;
      o_undef_data <= `UNDEF_READ;                                    // [RULE_17]
    end
  end

  // ------------------------------------------------------------
  // Buffer allocation and alternate settings
  // ------------------------------------------------------------
  // Layout is held in a register so a rejected index keeps the last one
  // Depths follow the held layout, two cycles behind the request
  // Endpoints 0 and 1 are never touched by the layout choice
  // Setting 0 reports every endpoint but ep0 as not implemented
  // Ep2 and ep6 step bulk, interrupt, iso across settings 1 to 3
  // Ep4 and ep8 are bulk in every setting that has them
  logic [3:0] layout;
  logic [3:0] next_layout;
  logic [11:0] next_depths;
  logic [9:0] next_pkt_ep1;
  logic [9:0] next_pkt_big;
  logic [1:0] next_type_ep1;
  logic [1:0] next_type_var;
  logic [1:0] next_type_fix;

  always_comb begin
    // Out-of-range layout selections are ignored
    next_layout = (i_layout <= `LAST_LAYOUT) ? i_layout : layout;    // [RULE_11]
    next_depths = layout_depths(layout);                              // [RULE_10] [RULE_11]
    next_pkt_big = i_high_speed ? `HS_PKT_MAX : `FS_PKT_MAX;         // [RULE_12]
    next_pkt_ep1 = `EP1_PKT_MAX;
    next_type_ep1 = epmap_pkg::xfer_off;
    next_type_var = epmap_pkg::xfer_off;
    next_type_fix = epmap_pkg::xfer_off;
    unique case (i_alt)
      2'h0: begin
        next_pkt_big = 10'h000;                                        // [RULE_14]
        next_pkt_ep1 = 10'h000;
      end
      2'h1: begin
        next_type_ep1 = epmap_pkg::xfer_bulk;
        next_type_var = epmap_pkg::xfer_bulk;
        next_type_fix = epmap_pkg::xfer_bulk;
        // Reported as 512 at high speed for compliance; host keeps to 64
        if (i_high_speed) begin
          next_pkt_ep1 = `HS_PKT_MAX;                                 // [RULE_15] [RULE_16]
        end
      end
      2'h2: begin
        next_type_ep1 = epmap_pkg::xfer_int;                          // [RULE_14]
        next_type_var = epmap_pkg::xfer_int;
        next_type_fix = epmap_pkg::xfer_bulk;
      end
      2'h3: begin
        next_type_ep1 = epmap_pkg::xfer_int;
        next_type_var = epmap_pkg::xfer_iso;                          // [RULE_10]
        next_type_fix = epmap_pkg::xfer_bulk;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      layout <= 4'h0;
      o_layout <= 4'h0;
      o_depth_ep2 <= 3'h0;
      o_depth_ep4 <= 3'h0;
      o_depth_ep6 <= 3'h0;
      o_depth_ep8 <= 3'h0;
      o_pkt_ep0 <= 10'h000;
      o_pkt_ep1 <= 10'h000;
      o_pkt_big <= 10'h000;
      o_type_ep1 <= 2'h0;
      o_type_ep2 <= 2'h0;
      o_type_ep4 <= 2'h0;
      o_type_ep6 <= 2'h0;
      o_type_ep8 <= 2'h0;
    end else begin
      layout <= next_layout;
      o_layout <= layout;
      o_depth_ep2 <= next_depths[11:9];
      o_depth_ep4 <= next_depths[8:6];
      o_depth_ep6 <= next_depths[5:3];
      o_depth_ep8 <= next_depths[2:0];
      o_pkt_ep0 <= `FS_PKT_MAX;                                        // [RULE_08]
      o_pkt_ep1 <= next_pkt_ep1;
      o_pkt_big <= next_pkt_big;
      o_type_ep1 <= next_type_ep1;                                    // [RULE_09]
      o_type_ep2 <= next_type_var;
      o_type_ep4 <= next_type_fix;
      o_type_ep6 <= next_type_var;
      o_type_ep8 <= next_type_fix;
    end
  end

endmodule

// ### common/epmap_defines.svh
// Address map and buffer layout constants for the endpoint memory decoder
`ifndef EPMAP_DEFINES_SVH
`define EPMAP_DEFINES_SVH

`define MAIN_RAM_TOP 16'h3fff
`define SCRATCH_BASE 16'he000
`define SCRATCH_TOP 16'he1ff
`define RSV0_BASE 16'he200
`define RSV0_TOP 16'he3ff
`define WAVE_BASE 16'he400
`define WAVE_TOP 16'he47f
`define RSV1_BASE 16'he480
`define RSV1_TOP 16'he4ff
`define CREG_BASE 16'he500
`define CREG_TOP 16'he6ff
`define SETUP_BASE 16'he6b8
`define SETUP_TOP 16'he6bf
`define RSV2_BASE 16'he700
`define RSV2_TOP 16'he73f
`define EP0_BASE 16'he740
`define EP0_TOP 16'he77f
`define ENDPOINT_ONE_OUT_BUFFER_BASE 16'he780
`define ENDPOINT_ONE_OUT_BUFFER_TOP 16'he7bf
`define ENDPOINT_ONE_IN_BUFFER_BASE 16'he7c0
`define ENDPOINT_ONE_IN_BUFFER_TOP 16'he7ff
`define RSV3_BASE 16'he800
`define RSV3_TOP 16'hefff
`define BIG_BASE 16'hf000
`define BIG_TOP 16'hffff
`define FS_PKT_MAX 10'h040
`define HS_PKT_MAX 10'h200
`define EP1_PKT_MAX 10'h040
`define LAST_LAYOUT 4'hb
`define LAST_ALT 2'h3
`define UNDEF_READ 8'hff

`endif

// ### common/epmap_pkg.sv
// Types shared by the endpoint memory decoder
package epmap_pkg;
  typedef enum logic [3:0] {
    reg_none, reg_main_ram, reg_scratch, reg_wave, reg_creg, reg_setup,
    reg_ep0, reg_ep1_out, reg_ep1_in, reg_big, reg_reserved
  } region_t;
  typedef enum logic [1:0] {xfer_off, xfer_bulk, xfer_int, xfer_iso} xfer_t;
endpackage

// ### sim/endpoint_buffer_memory_map_assertions.sv
// Port-level checks on the endpoint memory decoder
`timescale 1ns/1ps
module epmap_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_loader,
  input wire logic i_high_speed,
  input wire logic [1:0] i_alt,
  input wire logic [3:0] o_region,
  input wire logic o_hit,
  input wire logic o_wr_ok,
  input wire logic o_loader_ok,
  input wire logic [2:0] o_big_block,
  input wire logic o_fs_unused,
  input wire logic [3:0] o_layout,
  input wire logic [2:0] o_depth_ep4,
  input wire logic [2:0] o_depth_ep8,
  input wire logic [9:0] o_pkt_ep1,
  input wire logic [9:0] o_pkt_big
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] a;
  logic up;
  // Address and reset seen one edge back
  always_ff @(posedge i_clk_sys) begin
    a <= i_addr;
    up <= i_rst_n;
  end
  ram_decode_a: assert property (up && a <= 16'h3fff |-> o_region == 4'h1 && o_hit)
    else $error("main ram decode wrong");
  creg_decode_a: assert property (up && a >= 16'he500 && a <= 16'he6ff
    && a[15:3] != 13'h1cd7 |-> o_region == 4'h4) else $error("register window wrong");
  setup_buf_a: assert property (up && a[15:3] == 13'h1cd7 |-> o_region == 4'h5)
    else $error("setup buffer decode wrong");
  wave_decode_a: assert property (up && a[15:7] == 9'h1c8 |-> o_region == 4'h3)
    else $error("waveform window wrong");
  big_block_a: assert property (up && a[15:12] == 4'hf |-> o_region == 4'h9
    && o_big_block == a[11:9]) else $error("big buffer decode wrong");
  loader_scope_a: assert property (up |-> o_loader_ok == ($past(i_loader)
    && (o_region == 4'h1 || o_region == 4'h2))) else $error("loader scope wrong");
  fs_dead_a: assert property (up && a[15:12] == 4'hf && !$past(i_high_speed)
    && a[8:6] != 3'h0 |-> o_fs_unused && !o_wr_ok) else $error("dead space usable");
  reserved_a: assert property (o_region == 4'ha |-> !o_hit && !o_wr_ok)
    else $error("reserved range has effect");
  layout_range_a: assert property (o_layout <= 4'hb && o_depth_ep4 <= 3'h2
    && o_depth_ep8 <= 3'h2) else $error("layout or depth out of range");
  hs_pkt_a: assert property (up && $past(i_high_speed) && $past(i_alt) == 2'h1
    |-> o_pkt_ep1 == 10'h200 && o_pkt_big == 10'h200) else $error("hs packet wrong");
endmodule

bind endpoint_buffer_memory_map epmap_checker epmap_checker_i (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_loader(i_loader), .i_high_speed(i_high_speed),
  .i_alt(i_alt), .o_region(o_region), .o_hit(o_hit), .o_wr_ok(o_wr_ok),
  .o_loader_ok(o_loader_ok), .o_big_block(o_big_block), .o_fs_unused(o_fs_unused),
  .o_layout(o_layout), .o_depth_ep4(o_depth_ep4), .o_depth_ep8(o_depth_ep8),
  .o_pkt_ep1(o_pkt_ep1), .o_pkt_big(o_pkt_big));

// ### sim/host_access_model.sv
// Host side model presenting access addresses to the decoder
`timescale 1ns/1ps
module host_access_model (
  input wire logic [15:0] i_req_addr,
  output logic [15:0] o_addr
);
  // Requests pass through unchanged; endpoint 1 requests are not held inside its 64 bytes
  assign o_addr = i_req_addr;
endmodule

// ### sim/endpoint_buffer_memory_map_tb_top.sv
// Self-checking bench for the endpoint memory decoder
`timescale 1ns/1ps
module endpoint_buffer_memory_map_tb_top;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_loader = 1'b0, i_high_speed = 1'b1;
  logic [15:0] req = 16'h0000, i_addr;
  logic [3:0] i_layout = 4'h0, o_region, o_layout;
  logic [1:0] i_alt = 2'h0, o_type_ep1, o_type_ep2, o_type_ep4, o_type_ep6, o_type_ep8;
  logic o_hit, o_wr_ok, o_loader_ok, o_fs_unused;
  logic [2:0] o_big_block, o_depth_ep2, o_depth_ep4, o_depth_ep6, o_depth_ep8;
  logic [8:0] o_offset;
  logic [7:0] o_undef_data;
  logic [9:0] o_pkt_ep0, o_pkt_ep1, o_pkt_big;
  int miscompares = 0, samples_checked = 0;
  localparam logic [19:0] MAP [24] = '{20'h00001, 20'h3fff1, 20'h40000, 20'he0002, 20'he1ff2,
    20'he200a, 20'he3ffa, 20'he4003, 20'he47f3, 20'he480a, 20'he5004, 20'he6b74, 20'he6b85,
    20'he6bf5, 20'he6c04, 20'he6ff4, 20'he700a, 20'he7406, 20'he77f6, 20'he7807, 20'he7c08,
    20'he800a, 20'hefffa, 20'hf0009};
  localparam logic [15:0] DEPTHS [12] = '{16'h2222, 16'h2022, 16'h2220, 16'h2020, 16'h3022,
    16'h3030, 16'h2032, 16'h2040, 16'h4020, 16'h4040, 16'h3020, 16'h2030};

  always #10 i_clk_sys = ~i_clk_sys;

  host_access_model host_access_model_i (.i_req_addr(req), .o_addr(i_addr));
  endpoint_buffer_memory_map endpoint_buffer_memory_map_i (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_loader(i_loader),
    .i_high_speed(i_high_speed), .i_layout(i_layout), .i_alt(i_alt), .o_region(o_region),
    .o_hit(o_hit), .o_wr_ok(o_wr_ok), .o_loader_ok(o_loader_ok), .o_big_block(o_big_block),
    .o_offset(o_offset), .o_fs_unused(o_fs_unused), .o_undef_data(o_undef_data),
    .o_layout(o_layout), .o_depth_ep2(o_depth_ep2), .o_depth_ep4(o_depth_ep4),
    .o_depth_ep6(o_depth_ep6), .o_depth_ep8(o_depth_ep8), .o_pkt_ep0(o_pkt_ep0),
    .o_pkt_ep1(o_pkt_ep1), .o_pkt_big(o_pkt_big), .o_type_ep1(o_type_ep1),
    .o_type_ep2(o_type_ep2), .o_type_ep4(o_type_ep4), .o_type_ep6(o_type_ep6),
    .o_type_ep8(o_type_ep8));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One access, result looked at a cycle later
  task automatic access(input logic [15:0] ad, input logic ld, input logic hs);
    @(negedge i_clk_sys);
    req = ad;
    i_wr = 1'b1;
    i_loader = ld;
    i_high_speed = hs;
    @(negedge i_clk_sys);
  endtask

  task automatic t_map;
    logic [3:0] r;
    logic ram, hit;
    for (int ld = 0; ld < 2; ld++) begin
      foreach (MAP[k]) begin
        r = MAP[k][3:0];
        ram = (r == 4'h1) || (r == 4'h2);
        hit = (r != 4'h0) && (r != 4'ha);
        access(MAP[k][19:4], ld[0], 1'b1);
        chk(16'(o_region), 16'(r));
        chk(16'(o_hit), 16'(hit));
        chk(16'(o_loader_ok), 16'(ld[0] && ram));
        chk(16'(o_wr_ok), 16'(hit && (!ld[0] || ram)));
        chk(16'(o_undef_data), 16'h00ff);
      end
    end
  endtask

  task automatic fs_case(input logic [15:0] ad, input logic hs, input logic un);
    access(ad, 1'b0, hs);
    chk(16'(o_fs_unused), 16'(un));
    chk(16'(o_wr_ok), 16'(!un));
    chk({4'h0, o_big_block, o_offset}, {4'h0, ad[11:0]});
  endtask

  task automatic t_layout;
    for (int k = 0; k < 13; k++) begin
      @(negedge i_clk_sys);
      i_layout = 4'(k);
      repeat (2) @(negedge i_clk_sys);
      chk({1'b0, o_depth_ep2, 1'b0, o_depth_ep4, 1'b0, o_depth_ep6, 1'b0, o_depth_ep8},
        DEPTHS[(k > 11) ? 11 : k]);
      chk(16'(o_layout), 16'((k > 11) ? 11 : k));
    end
  endtask

  task automatic t_alt;
    logic [1:0] t1, b, s2;
    for (int h = 0; h < 2; h++) begin
      for (int s = 0; s < 4; s++) begin
        @(negedge i_clk_sys);
        i_high_speed = h[0];
        i_alt = 2'(s);
        @(negedge i_clk_sys);
        s2 = 2'(s);
        t1 = (s > 1) ? 2'h2 : s2;
        b = (s != 0) ? 2'h1 : 2'h0;
        chk(16'(o_pkt_ep0), 16'h0040);
        chk(16'(o_pkt_ep1), (s == 0) ? 16'h0 : (s == 1 && h == 1) ? 16'h200 : 16'h40);
        chk(16'(o_pkt_big), (s == 0) ? 16'h0 : (h == 1) ? 16'h200 : 16'h40);
        chk({o_type_ep1, o_type_ep2, o_type_ep4, o_type_ep6, o_type_ep8, 6'h00},
          {t1, s2, b, s2, b, 6'h00});
      end
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_map();
    fs_case(16'hf03f, 1'b0, 1'b0);
    fs_case(16'hf040, 1'b0, 1'b1);
    fs_case(16'hffff, 1'b0, 1'b1);
    fs_case(16'hffff, 1'b1, 1'b0);
    t_layout();
    t_alt();
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
